// file: hdl/debug_link_regs.sv
// register, time-out and pacing block of a single-wire debug link
// assumes a link framer drives the register strobes, error events
// and byte/turnaround requests, all synchronous to clock
// Functional notes
// - registers reachable only through debug link port
// - phy registers 0x0-0x3, access registers 0x4-0xC
// - read-only revision field in bits 7:4
// - error signature loaded on error, cleared on read
// - error codes parity, frame, clock, contention
// - access time-out code 3, bit4 disables
// - bit7 inserts two idle characters between bytes
// - bit5 ignores parity, no parity error
// - bit3 suppresses all response signatures
// - guard-time field selects turnaround idle bits
// - control-B bit4 suppresses reset negative acknowledge
// - control-B bit3 disables contention detection
// - control-B bit2 resets interface and keys
// - user-row key bit, writable, reads key state
// - programming key bit clears when programming done
// - erase key bit clears when erase completes
// - valid key signature activates matching key
// - 0x59 holds system reset, other value releases
`timescale 1ns/1ns
`default_nettype none
module debug_link_regs
  import debug_link_pkg::*;
#(
  parameter logic [3:0] REVISION       = 4'h5,   // arbitrary value
  parameter int         TIMEOUT_LIMIT  = TIMEOUT_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       reset_n,
  // register port from the link framer
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  input  wire logic [3:0] reg_address,
  input  wire logic [7:0] reg_write_data,
  output var  logic [7:0] reg_read_data,
  // error events from the framer
  input  wire logic       parity_error,
  input  wire logic       frame_error,
  input  wire logic       clock_error,
  input  wire logic       contention_error,
  // access layer wait tracking
  input  wire logic       access_pending,
  input  wire logic       access_done,
  // key decoder and system events
  input  wire logic       erase_key_valid,
  input  wire logic       program_key_valid,
  input  wire logic       user_row_key_valid,
  input  wire logic       erase_complete,
  input  wire logic       program_complete,
  input  wire logic       system_reset_during_access,
  input  wire logic [7:0] system_status_in,
  input  wire logic [2:0] scan_status_in,
  // transmit pacing
  input  wire logic       turnaround_start,
  input  wire logic       next_byte_start,
  output logic            transmit_hold,
  // framer controls
  output logic            parity_check_off,
  output logic            response_signature_off,
  output logic            negative_ack_send,
  output logic            interface_disable,
  output logic            clock_request,
  output logic [1:0]      clock_select,
  output logic            system_reset_request,
  output logic            erase_key_active,
  output logic            memory_program_key_active,
  output logic            user_row_key_active,
  output logic            user_row_final
);

  // one-hot pacing states; any other code falls back to idle
  typedef enum logic [2:0] {
    PACE_IDLE  = 3'b001,
    PACE_GUARD = 3'b010,
    PACE_GAP   = 3'b100
  } pace_state_t;

  localparam int GAP_BITS = IDLE_CHAR_BITS * GAP_CHARS;
  localparam logic [7:0] SYS_STATUS_MASK = 8'h3D;  // only the defined status bits pass

  logic [7:0]  phy_control;
  logic [7:0]  phy_disable;
  logic [2:0]  link_error_signature;
  logic [16:0] timeout_count;
  logic [7:0]  pace_count;
  pace_state_t pace_state;
  logic        soft_reset;

  // write strobe decode shared by every writable register
  function automatic logic hit(input logic [3:0] ofs);
    hit = reg_write && (reg_address == ofs);
  endfunction : hit

  // guard length halves per code step; the top code turns it off
  function automatic logic [7:0] guard_bits(input logic [2:0] code);
    guard_bits = (code == GUARD_OFF) ? 8'h00 : (GUARD_BASE >> code);
  endfunction : guard_bits

  // a disable write resets the link side, not the system reset hold
  assign soft_reset = hit(OFS_PHY_DIS) && reg_write_data[DIS_IF_BIT];

  // reserved bits are masked off here, so reads return zero there
  always_ff @(posedge clock) begin
    if (!reset_n || soft_reset) begin
      phy_control <= 8'h00;
    end else if (hit(OFS_PHY_CTRL)) begin
      phy_control <= reg_write_data & PHY_CTRL_MASK;
    end
  end

  // the disable bit is a strobe and is never stored
  always_ff @(posedge clock) begin
    if (!reset_n || soft_reset) begin
      phy_disable <= 8'h00;
    end else if (hit(OFS_PHY_DIS)) begin
      phy_disable <= reg_write_data & PHY_DIS_MASK;
    end
  end

  // the error field is sticky until read; a new error wins over the read clear
  always_ff @(posedge clock) begin
    if (!reset_n || soft_reset) begin
      link_error_signature <= ERR_NONE;
    end else if (contention_error && !phy_disable[DIS_CONT_BIT]) begin
      link_error_signature <= ERR_CONTENTION;
    end else if (clock_error) begin
      link_error_signature <= ERR_CLOCK;
    end else if (frame_error) begin
      link_error_signature <= ERR_FRAME;
    end else if (parity_error && !phy_control[CTRL_PARITY_BIT]) begin
      link_error_signature <= ERR_PARITY;
      // loaded once per wait, on the cycle the limit is reached
    end else if (timeout_count == 17'(TIMEOUT_LIMIT) && !phy_control[CTRL_TIMEOUT_BIT]) begin
      link_error_signature <= ERR_TIMEOUT;
    end else if (reg_read && reg_address == OFS_ERROR) begin
      link_error_signature <= ERR_NONE;
    end
  end

  // counts wait cycles; fires once at the limit, then holds
  always_ff @(posedge clock) begin
    if (!reset_n || soft_reset || !access_pending || access_done) begin
      timeout_count <= 17'h00000;
    end else if (timeout_count <= 17'(TIMEOUT_LIMIT)) begin
      timeout_count <= timeout_count + 17'h00001;
    end
  end

  // keys: a new key wins over a completion in the same cycle
  always_ff @(posedge clock) begin
    if (!reset_n || soft_reset) begin
      erase_key_active <= 1'b0;
    end else if (erase_key_valid) begin
      erase_key_active <= 1'b1;
    end else if (erase_complete) begin
      erase_key_active <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n || soft_reset) begin
      memory_program_key_active <= 1'b0;
    end else if (program_key_valid) begin
      memory_program_key_active <= 1'b1;
    end else if (program_complete) begin
      memory_program_key_active <= 1'b0;
    end
  end

  // the user-row key has no completion event; the debugger drops it by writing its bit
  always_ff @(posedge clock) begin
    if (!reset_n || soft_reset) begin
      user_row_key_active <= 1'b0;
    end else if (user_row_key_valid) begin
      user_row_key_active <= 1'b1;
    end else if (hit(OFS_KEY_STATUS) && reg_write_data[KEY_UROW_BIT]) begin
      user_row_key_active <= 1'b0;
    end
  end

  // system reset hold survives an interface disable on purpose
  // any value but the signature releases the system
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      system_reset_request <= 1'b0;
    end else if (hit(OFS_RESET_REQ)) begin
      system_reset_request <= (reg_write_data == RESET_SIGNATURE);
    end
  end

  // a disable lowers the clock request; a full reset or a write of its bit raises it again
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      clock_request <= 1'b1;
    end else if (soft_reset) begin
      clock_request <= 1'b0;
    end else if (hit(OFS_SYS_CTRL)) begin
      clock_request <= reg_write_data[SYS_CLKREQ_BIT];
    end
  end

  // the final strobe only takes while the user-row key is active
  always_ff @(posedge clock) begin
    if (!reset_n || soft_reset) begin
      user_row_final <= 1'b0;
    end else if (hit(OFS_SYS_CTRL)) begin
      user_row_final <= reg_write_data[SYS_FINAL_BIT] && user_row_key_active;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n || soft_reset) begin
      clock_select <= CLOCK_SEL_RESET;
    end else if (hit(OFS_CLOCK_SEL)) begin
      clock_select <= reg_write_data[1:0];
    end
  end

  // disable raises interface_disable for one cycle, in the same edge as the reset
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      interface_disable <= 1'b0;
    end else begin
      interface_disable <= soft_reset;
    end
  end

  // copies run one cycle behind the control register
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      parity_check_off <= 1'b0;
    end else begin
      parity_check_off <= phy_control[CTRL_PARITY_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      response_signature_off <= 1'b0;
    end else begin
      response_signature_off <= phy_control[CTRL_RESP_BIT];
    end
  end

  // no acknowledge of any kind while responses are off
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      negative_ack_send <= 1'b0;
    end else begin
      negative_ack_send <= system_reset_during_access && !phy_disable[DIS_NACK_BIT]
                           && !phy_control[CTRL_RESP_BIT];
    end
  end

  // pacing: guard before the first byte, fixed gap between later ones
  always_ff @(posedge clock) begin
    if (!reset_n || soft_reset) begin
      pace_state    <= PACE_IDLE;
      pace_count    <= 8'h00;
      transmit_hold <= 1'b0;
    end else begin
      case (pace_state)
        PACE_IDLE: begin
          // turnaround wins over a gap request in the same cycle unless the guard is off
          if (turnaround_start && guard_bits(phy_control[2:0]) != 8'h00) begin
            pace_state    <= PACE_GUARD;
            pace_count    <= guard_bits(phy_control[2:0]);
            transmit_hold <= 1'b1;
          end else if (next_byte_start && phy_control[CTRL_GAP_BIT]) begin
            pace_state    <= PACE_GAP;
            pace_count    <= 8'(GAP_BITS);
            transmit_hold <= 1'b1;
          end
        end
        PACE_GUARD, PACE_GAP: begin
          if (pace_count == 8'h01) begin
            pace_state    <= PACE_IDLE;
            transmit_hold <= 1'b0;
          end
          pace_count <= pace_count - 8'h01;
        end
        default: begin
          pace_state    <= PACE_IDLE;
          transmit_hold <= 1'b0;
        end
      endcase
    end
  end

  // read mux: only the link port reaches this data path
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      reg_read_data <= 8'h00;
    end else if (reg_read) begin
      case (reg_address)
        OFS_REVISION: begin
          reg_read_data <= {REVISION, 4'h0};
        end
        OFS_ERROR: begin
          reg_read_data <= {5'h00, link_error_signature};
        end
        OFS_PHY_CTRL: begin
          reg_read_data <= phy_control;
        end
        OFS_PHY_DIS: begin
          reg_read_data <= phy_disable;
        end
        OFS_KEY_STATUS: begin
          reg_read_data <= {2'h0, user_row_key_active, memory_program_key_active,
                            erase_key_active, 3'h0};
        end
        OFS_RESET_REQ: begin
          reg_read_data <= {7'h00, system_reset_request};
        end
        OFS_CLOCK_SEL: begin
          reg_read_data <= {6'h00, clock_select};
        end
        OFS_SYS_CTRL: begin
          reg_read_data <= {6'h00, user_row_final, clock_request};
        end
        OFS_SYS_STATUS: begin
          reg_read_data <= system_status_in & SYS_STATUS_MASK;
        end
        OFS_SCAN_CHECK: begin
          reg_read_data <= {5'h00, scan_status_in};
        end
        // reserved offsets read zero
        default: begin
          reg_read_data <= 8'h00;
        end
      endcase
    end
  end

endmodule : debug_link_regs
`default_nettype wire

// file: hdl/debug_link_pkg.sv
// package for the single-wire debug link register block
// shared by the register block and its bench; no other assumptions
package debug_link_pkg;
  // register offsets in the debug register space
  localparam logic [3:0] OFS_REVISION   = 4'h0;
  localparam logic [3:0] OFS_ERROR      = 4'h1;
  localparam logic [3:0] OFS_PHY_CTRL   = 4'h2;
  localparam logic [3:0] OFS_PHY_DIS    = 4'h3;
  localparam logic [3:0] OFS_KEY_STATUS = 4'h7;
  localparam logic [3:0] OFS_RESET_REQ  = 4'h8;
  localparam logic [3:0] OFS_CLOCK_SEL  = 4'h9;
  localparam logic [3:0] OFS_SYS_CTRL   = 4'hA;
  localparam logic [3:0] OFS_SYS_STATUS = 4'hB;
  localparam logic [3:0] OFS_SCAN_CHECK = 4'hC;

  // field positions
  localparam int REV_LSB         = 4;
  localparam int CTRL_GAP_BIT    = 7;
  localparam int CTRL_PARITY_BIT = 5;
  localparam int CTRL_TIMEOUT_BIT= 4;
  localparam int CTRL_RESP_BIT   = 3;
  localparam int DIS_NACK_BIT    = 4;
  localparam int DIS_CONT_BIT    = 3;
  localparam int DIS_IF_BIT      = 2;
  localparam int KEY_UROW_BIT    = 5;
  localparam int KEY_PROG_BIT    = 4;
  localparam int KEY_ERASE_BIT   = 3;
  localparam int SYS_FINAL_BIT   = 1;
  localparam int SYS_CLKREQ_BIT  = 0;

  // masks of writable bits, and the clock select reset value
  localparam logic [7:0] PHY_CTRL_MASK = 8'hBF;
  localparam logic [7:0] PHY_DIS_MASK  = 8'h18;
  localparam logic [1:0] CLOCK_SEL_RESET = 2'h3;

  // error signature codes
  localparam logic [2:0] ERR_NONE       = 3'h0;
  localparam logic [2:0] ERR_PARITY     = 3'h1;
  localparam logic [2:0] ERR_FRAME      = 3'h2;
  localparam logic [2:0] ERR_TIMEOUT    = 3'h3;
  localparam logic [2:0] ERR_CLOCK      = 3'h4;
  localparam logic [2:0] ERR_CONTENTION = 3'h7;

  localparam logic [7:0] RESET_SIGNATURE = 8'h59;

  // time-out in interface clock cycles
  localparam int TIMEOUT_CYCLES = 65536;
  // inter-byte gap: two idle characters of twelve bit times
  localparam int IDLE_CHAR_BITS = 12;
  localparam int GAP_CHARS      = 2;
  localparam logic [2:0] GUARD_OFF = 3'h7;
  localparam logic [7:0] GUARD_BASE = 8'h80;
endpackage : debug_link_pkg

// file: testbench/debug_link_properties.sv
// port checker of the debug link register block
// bound into debug_link_regs; one clock, synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module debug_link_properties
  import debug_link_pkg::*;
#(
  parameter logic [3:0] REVISION = 4'h5
) (
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [3:0] reg_address,
  input wire logic [7:0] reg_write_data,
  input wire logic [7:0] reg_read_data,
  input wire logic       system_reset_during_access,
  input wire logic       erase_key_valid,
  input wire logic       erase_complete,
  input wire logic       parity_check_off,
  input wire logic       response_signature_off,
  input wire logic       negative_ack_send,
  input wire logic       interface_disable,
  input wire logic       system_reset_request,
  input wire logic       erase_key_active
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_revision; reg_read && reg_address == OFS_REVISION |=> reg_read_data == {REVISION, 4'h0}; endproperty
  a_revision: assert property (p_revision) else $error("revision read wrong");
  property p_reserved; reg_read && reg_address inside {4'h4, 4'h5, 4'h6} |=> reg_read_data == 8'h00; endproperty
  a_reserved: assert property (p_reserved) else $error("reserved offset not zero");
  property p_error_field;
    reg_read && reg_address == OFS_ERROR |=> reg_read_data[7:3] == 5'h00 && !(reg_read_data[2:0] inside {3'h5, 3'h6});
  endproperty
  a_error_field: assert property (p_error_field) else $error("error status field bad");
  // copy lags the register by one cycle, so look two edges on
  property p_parity_follow;
    reg_write && reg_address == OFS_PHY_CTRL |-> ##2 parity_check_off == $past(reg_write_data[CTRL_PARITY_BIT], 2);
  endproperty
  a_parity_follow: assert property (p_parity_follow) else $error("parity off not following");
  property p_nack_gate;
    system_reset_during_access && response_signature_off |=> !negative_ack_send || !response_signature_off;
  endproperty
  a_nack_gate: assert property (p_nack_gate) else $error("nack sent while responses off");
  property p_disable_pulse;
    reg_write && reg_address == OFS_PHY_DIS && reg_write_data[DIS_IF_BIT] |=> interface_disable ##1 !interface_disable;
  endproperty
  a_disable_pulse: assert property (p_disable_pulse) else $error("disable pulse wrong");
  property p_reset_req;
    reg_write && reg_address == OFS_RESET_REQ |=> system_reset_request == ($past(reg_write_data) == RESET_SIGNATURE);
  endproperty
  a_reset_req: assert property (p_reset_req) else $error("system reset request wrong");
  property p_erase_key;
    erase_key_valid && !erase_complete && !(reg_write && reg_address == OFS_PHY_DIS) |=> erase_key_active;
  endproperty
  a_erase_key: assert property (p_erase_key) else $error("erase key not active");
endmodule : debug_link_properties
bind debug_link_regs debug_link_properties #(.REVISION(REVISION)) props_u (.clock, .reset_n, .reg_write, .reg_read,
  .reg_address, .reg_write_data, .reg_read_data, .system_reset_during_access, .erase_key_valid, .erase_complete,
  .parity_check_off, .response_signature_off, .negative_ack_send, .interface_disable, .system_reset_request,
  .erase_key_active);
`default_nettype wire

// file: testbench/debugger_model.sv
// debugger side of the register port, one byte per request
// assumes one clock; changes its lines at the falling edge
`timescale 1ns/1ns
`default_nettype none
module debugger_model (
  input  wire logic       clock,
  output logic            reg_write,
  output logic            reg_read,
  output logic [3:0]      reg_address,
  output logic [7:0]      reg_write_data
);
  logic [7:0] exp_q[$];
  initial begin
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_address = 4'hF;
    reg_write_data = 8'h00;
  end
  // released lines show the inverse, so a stale value is never trusted
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_write <= w;
    reg_read <= !w;
    reg_address <= a;
    reg_write_data <= d;
    @(negedge clock);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    reg_address <= ~a;
    reg_write_data <= ~d;
  endtask : xfer
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, ~e);
  endtask : rd
endmodule : debugger_model
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench of the debug link register block
// debugger model drives the register port; bench drives events and levels
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import debug_link_pkg::*;
  localparam logic [3:0] REV = 4'hA;  // arbitrary value
  logic        clock;
  logic        reset_n;
  logic [12:0] pulses;
  logic        access_pending;
  logic [7:0]  sys_status;
  logic [2:0]  scan_status;
  logic        reg_write;
  logic        reg_read;
  logic [3:0]  reg_address;
  logic [7:0]  reg_write_data;
  logic [7:0]  reg_read_data;
  logic        transmit_hold;
  logic        negative_ack_send;
  logic        rd_seen;
  logic [7:0]  r;
  int          errors;
  int          compares;
  int          nacks;
  debugger_model dbg_u (.clock(clock), .reg_write(reg_write), .reg_read(reg_read), .reg_address(reg_address),
    .reg_write_data(reg_write_data));
  debug_link_regs #(.REVISION(REV), .TIMEOUT_LIMIT(16)) dut_u (.clock(clock), .reset_n(reset_n),
    .reg_write(reg_write), .reg_read(reg_read), .reg_address(reg_address), .reg_write_data(reg_write_data),
    .reg_read_data(reg_read_data), .parity_error(pulses[0]), .frame_error(pulses[1]), .clock_error(pulses[2]),
    .contention_error(pulses[3]), .erase_key_valid(pulses[4]), .program_key_valid(pulses[5]),
    .user_row_key_valid(pulses[6]), .erase_complete(pulses[7]), .program_complete(pulses[8]),
    .system_reset_during_access(pulses[9]), .turnaround_start(pulses[10]), .next_byte_start(pulses[11]),
    .access_done(pulses[12]), .access_pending(access_pending), .system_status_in(sys_status),
    .scan_status_in(scan_status), .transmit_hold(transmit_hold), .parity_check_off(), .response_signature_off(),
    .negative_ack_send(negative_ack_send), .interface_disable(), .clock_request(), .clock_select(),
    .system_reset_request(), .erase_key_active(), .memory_program_key_active(), .user_row_key_active(),
    .user_row_final());
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic pulse(input int b);
    @(negedge clock);
    pulses[b] <= 1'b1;
    @(negedge clock);
    pulses[b] <= 1'b0;
  endtask : pulse
  // fixed window: counts every held cycle, wherever the hold begins
  task automatic hold_len(input int b, input logic [7:0] exp);
    int n;
    pulse(b);
    n = (transmit_hold === 1'b1);
    repeat (300) begin
      @(negedge clock);
      if (transmit_hold === 1'b1) n++;
    end
    check(n[7:0], exp);
  endtask : hold_len
  always @(posedge clock) rd_seen <= reg_read;
  always @(negedge clock) if (negative_ack_send === 1'b1) nacks++;
  always @(negedge clock) if (rd_seen === 1'b1) check(reg_read_data, dbg_u.exp_q.pop_front());
  // a stalled run still reaches the verdict
  initial begin
    #400000;
    errors++;
    test_done();
  end
  initial begin
    reset_n = 1'b0;
    pulses = '0;
    access_pending = 1'b0;
    sys_status = 8'h00;
    scan_status = 3'h0;
    errors = 0;
    compares = 0;
    nacks = 0;
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    void'($urandom(33));
    for (int a = 0; a < 13; a++)
      dbg_u.rd(a[3:0], (a == 0) ? {REV, 4'h0} : (a == 9) ? 8'h03 : (a == 10) ? 8'h01 : 8'h00);
    dbg_u.wr(OFS_REVISION, 8'hFF);
    dbg_u.rd(OFS_REVISION, {REV, 4'h0});
    for (int i = 0; i < 4; i++) begin
      pulse(i);
      dbg_u.rd(OFS_ERROR, (i == 3) ? {5'h00, ERR_CONTENTION} : 8'h01 << i);
      dbg_u.rd(OFS_ERROR, 8'h00);
    end
    dbg_u.wr(OFS_PHY_CTRL, 8'h20);
    pulse(0);
    dbg_u.rd(OFS_ERROR, 8'h00);
    dbg_u.wr(OFS_PHY_CTRL, 8'h00);
    dbg_u.wr(OFS_PHY_DIS, 8'h18);
    dbg_u.rd(OFS_PHY_DIS, 8'h18);
    pulse(3);
    dbg_u.rd(OFS_ERROR, 8'h00);
    dbg_u.wr(OFS_PHY_DIS, 8'h00);
    for (int d = 0; d < 2; d++) begin
      dbg_u.wr(OFS_PHY_CTRL, d ? 8'h10 : 8'h00);
      access_pending = 1'b1;
      repeat (20) @(negedge clock);
      pulse(12);
      access_pending = 1'b0;
      dbg_u.rd(OFS_ERROR, d ? 8'h00 : 8'h03);
    end
    for (int g = 0; g < 8; g++) begin
      dbg_u.wr(OFS_PHY_CTRL, g[7:0]);
      hold_len(10, (g == 7) ? 8'h00 : 8'h80 >> g);
    end
    dbg_u.wr(OFS_PHY_CTRL, 8'h87);
    hold_len(11, 8'h18);
    dbg_u.wr(OFS_PHY_CTRL, 8'h07);
    hold_len(11, 8'h00);
    pulse(9);
    dbg_u.wr(OFS_PHY_CTRL, 8'h08);
    pulse(9);
    dbg_u.wr(OFS_PHY_CTRL, 8'h00);
    dbg_u.wr(OFS_PHY_DIS, 8'h10);
    pulse(9);
    repeat (2) @(negedge clock);
    check(nacks[7:0], 8'h01);
    for (int k = 0; k < 3; k++) begin
      pulse(4 + k);
      dbg_u.rd(OFS_KEY_STATUS, 8'h08 << k);
      if (k < 2) pulse(7 + k);
      else dbg_u.wr(OFS_KEY_STATUS, 8'h20);
      dbg_u.rd(OFS_KEY_STATUS, 8'h00);
    end
    pulse(4);
    pulse(6);
    dbg_u.wr(OFS_PHY_CTRL, 8'hBF);
    dbg_u.wr(OFS_RESET_REQ, RESET_SIGNATURE);
    dbg_u.rd(OFS_RESET_REQ, 8'h01);
    dbg_u.wr(OFS_PHY_DIS, 8'h1C);
    dbg_u.rd(OFS_KEY_STATUS, 8'h00);
    dbg_u.rd(OFS_PHY_CTRL, 8'h00);
    dbg_u.rd(OFS_PHY_DIS, 8'h00);
    dbg_u.rd(OFS_SYS_CTRL, 8'h00);
    dbg_u.rd(OFS_RESET_REQ, 8'h01);
    dbg_u.wr(OFS_RESET_REQ, 8'h00);
    dbg_u.rd(OFS_RESET_REQ, 8'h00);
    repeat (4) begin
      r = 8'($urandom);
      sys_status = r;
      scan_status = r[2:0];
      dbg_u.wr(OFS_PHY_CTRL, r);
      dbg_u.rd(OFS_PHY_CTRL, r & PHY_CTRL_MASK);
      dbg_u.wr(4'h5, r);
      dbg_u.rd(4'h5, 8'h00);
      dbg_u.rd(OFS_SYS_STATUS, r & 8'h3D);
      dbg_u.rd(OFS_SCAN_CHECK, {5'h00, r[2:0]});
    end
    repeat (3) @(negedge clock);
    test_done();
  end
endmodule : testbench
`default_nettype wire
